/* File: src/rx_counter_latch_config.v */
`timescale 1ns/1ps
`default_nettype none
`include "rx_counter_latch_regs.vh"

module rx_counter_latch_config #(
    parameter [`TICK_W-1:0] ONE_SEC_CYCLES = `ONE_SEC_CYCLES
) (
    // clock and reset
    input wire i_clk_sys,
    input wire i_srst,
    // processor port, strobes one cycle wide on i_clk_sys
    input wire i_cs,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    output reg o_rvalid,
    // receive alarms and error events from the framer
    input wire i_rx_frame_loss,
    input wire i_rx_signal_loss,
    input wire i_rx_all_ones_alarm,
    input wire i_carrier_group_alarm,
    input wire i_cga_from_yellow,
    input wire i_e1_mode,
    input wire [`NUM_ERR_CNT-1:0] i_err_evt,
    input wire i_test_pattern_err,
    // status and controls to the rest of the framer
    output reg o_one_second_tick,
    output reg o_perf_inhibit,
    output reg o_lof_timeout_valid,
    output reg o_alarm_status_hold_en,
    output reg o_error_status_latch_en,
    output reg o_counts_frozen
);
    reg [`CFG_W-1:0] cfg_q;
    reg [`TICK_W-1:0] tick_cnt_q;
    reg tick_q;
    reg [7:0] rdata_d;
    wire wr_en;
    wire rd_en;
    wire latch_en;
    wire freeze;
    wire [`NUM_ERR_CNT-1:0] rd_lo;
    wire [`NUM_ERR_CNT-1:0] rd_hi;
    wire [8*`NUM_ERR_CNT-1:0] lo_bytes;
    wire [8*`NUM_ERR_CNT-1:0] hi_bytes;
    wire [7:0] tp_lo;
    wire [7:0] tp_hi;
    wire [7:0] cnt_off;
    wire in_cnt;

    assign wr_en = i_cs & i_wr;
    assign rd_en = i_cs & i_rd;
    assign latch_en = cfg_q[`BIT_CNT_LATCH];
    assign freeze = cfg_q[`BIT_FREEZE] & (i_rx_frame_loss | i_rx_signal_loss | i_rx_all_ones_alarm);
    assign in_cnt = (i_addr >= `ADDR_CNT_BASE) && (i_addr <= `ADDR_CNT_LAST);
    assign cnt_off = i_addr - `ADDR_CNT_BASE;

    // reserved bits are not stored, so a stray one written there is harmless
    always @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            cfg_q <= `CFG_RESET;
        end
        else if (wr_en && i_addr == `ADDR_LATCH_CFG)
        begin
            cfg_q <= i_wdata[`CFG_W-1:0];
        end
    end

    // free-running timebase; the same tick goes to every counter and out to the monitor
    always @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            tick_cnt_q <= `TICK_ZERO;
            tick_q <= 1'b0;
        end
        else if (tick_cnt_q == ONE_SEC_CYCLES - `TICK_ONE)
        begin
            tick_cnt_q <= `TICK_ZERO;
            tick_q <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + `TICK_ONE;
            tick_q <= 1'b0;
        end
    end

    // even address strobes the low byte, odd the high byte; in_cnt keeps cnt_off within 0..7
    assign rd_lo[0] = rd_en & in_cnt & ~cnt_off[0] & (cnt_off[2:1] == 2'h0);
    assign rd_hi[0] = rd_en & in_cnt & cnt_off[0] & (cnt_off[2:1] == 2'h0);
    assign rd_lo[1] = rd_en & in_cnt & ~cnt_off[0] & (cnt_off[2:1] == 2'h1);
    assign rd_hi[1] = rd_en & in_cnt & cnt_off[0] & (cnt_off[2:1] == 2'h1);
    assign rd_lo[2] = rd_en & in_cnt & ~cnt_off[0] & (cnt_off[2:1] == 2'h2);
    assign rd_hi[2] = rd_en & in_cnt & cnt_off[0] & (cnt_off[2:1] == 2'h2);
    assign rd_lo[3] = rd_en & in_cnt & ~cnt_off[0] & (cnt_off[2:1] == 2'h3);
    assign rd_hi[3] = rd_en & in_cnt & cnt_off[0] & (cnt_off[2:1] == 2'h3);

    count_channel u_ch0 (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_evt(i_err_evt[0]),
        .i_freeze(freeze),
        .i_latch_en(latch_en),
        .i_tick(tick_q),
        .i_rd_lo(rd_lo[0]),
        .i_rd_hi(rd_hi[0]),
        .o_lo(lo_bytes[7:0]),
        .o_hi(hi_bytes[7:0])
    );

    count_channel u_ch1 (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_evt(i_err_evt[1]),
        .i_freeze(freeze),
        .i_latch_en(latch_en),
        .i_tick(tick_q),
        .i_rd_lo(rd_lo[1]),
        .i_rd_hi(rd_hi[1]),
        .o_lo(lo_bytes[15:8]),
        .o_hi(hi_bytes[15:8])
    );

    count_channel u_ch2 (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_evt(i_err_evt[2]),
        .i_freeze(freeze),
        .i_latch_en(latch_en),
        .i_tick(tick_q),
        .i_rd_lo(rd_lo[2]),
        .i_rd_hi(rd_hi[2]),
        .o_lo(lo_bytes[23:16]),
        .o_hi(hi_bytes[23:16])
    );

    count_channel u_ch3 (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_evt(i_err_evt[3]),
        .i_freeze(freeze),
        .i_latch_en(latch_en),
        .i_tick(tick_q),
        .i_rd_lo(rd_lo[3]),
        .i_rd_hi(rd_hi[3]),
        .o_lo(lo_bytes[31:24]),
        .o_hi(hi_bytes[31:24])
    );

    // test pattern errors keep counting through alarms
    count_channel u_tpat (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_evt(i_test_pattern_err),
        .i_freeze(1'b0),
        .i_latch_en(latch_en),
        .i_tick(tick_q),
        .i_rd_lo(rd_en && i_addr == `ADDR_TPAT_LO),
        .i_rd_hi(rd_en && i_addr == `ADDR_TPAT_HI),
        .o_lo(tp_lo),
        .o_hi(tp_hi)
    );

    always @*
    begin
        rdata_d = `BYTE_ZERO;
        if (i_addr == `ADDR_LATCH_CFG)
        begin
            rdata_d = {`CFG_PAD, cfg_q};
        end
        else if (in_cnt)
        begin
            rdata_d = cnt_off[0] ? hi_bytes[8*cnt_off[2:1] +: 8] : lo_bytes[8*cnt_off[2:1] +: 8];
        end
        else if (i_addr == `ADDR_TPAT_LO)
        begin
            rdata_d = tp_lo;
        end
        else if (i_addr == `ADDR_TPAT_HI)
        begin
            rdata_d = tp_hi;
        end
    end

    always @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_rdata <= `BYTE_ZERO;
            o_rvalid <= 1'b0;
            o_one_second_tick <= 1'b0;
            o_perf_inhibit <= 1'b0;
            o_lof_timeout_valid <= 1'b1;
            o_alarm_status_hold_en <= 1'b0;
            o_error_status_latch_en <= 1'b0;
            o_counts_frozen <= 1'b0;
        end
        else
        begin
            o_rvalid <= rd_en;
            if (rd_en)
            begin
                o_rdata <= rdata_d;
            end
            o_one_second_tick <= tick_q;
            o_perf_inhibit <= i_carrier_group_alarm & ~i_cga_from_yellow;
            o_lof_timeout_valid <= ~(i_e1_mode & latch_en);
            o_alarm_status_hold_en <= cfg_q[`BIT_ALM_HOLD];
            o_error_status_latch_en <= cfg_q[`BIT_ERR_LATCH];
            o_counts_frozen <= freeze;
        end
    end
endmodule // rx_counter_latch_config

`default_nettype wire

/* File: src/rx_counter_latch_regs.vh */
`ifndef RX_COUNTER_LATCH_REGS_VH
`define RX_COUNTER_LATCH_REGS_VH

// register map (byte addresses on the 8-bit processor port)
`define ADDR_LATCH_CFG 8'h46
`define ADDR_CNT_BASE 8'h50
`define ADDR_CNT_LAST 8'h57
`define ADDR_TPAT_LO 8'h58
`define ADDR_TPAT_HI 8'h59

// latch configuration fields
`define CFG_W 4
`define CFG_RESET 4'h0
`define BIT_ALM_HOLD 0
`define BIT_ERR_LATCH 1
`define BIT_CNT_LATCH 2
`define BIT_FREEZE 3
`define CFG_PAD 4'h0

// counters
`define NUM_ERR_CNT 4
`define CNT_W 16
`define CNT_ZERO 16'h0000
`define CNT_MAX 16'hFFFF
`define BYTE_ZERO 8'h00

// one-second timebase
`define CLK_HZ 200000000
`define ONE_SECOND_S 1
`define ONE_SEC_CYCLES (`ONE_SECOND_S * `CLK_HZ)
`define TICK_W 28
`define TICK_ZERO 28'h0000000
`define TICK_ONE 28'h0000001

`endif

/* File: src/count_channel.v */
`timescale 1ns/1ps
`default_nettype none
`include "rx_counter_latch_regs.vh"

module count_channel (
    // clock and reset
    input wire i_clk_sys,
    input wire i_srst,
    // controls
    input wire i_evt,
    input wire i_freeze,
    input wire i_latch_en,
    input wire i_tick,
    // processor reads
    input wire i_rd_lo,
    input wire i_rd_hi,
    // read data
    output wire [7:0] o_lo,
    output wire [7:0] o_hi
);
    reg [`CNT_W-1:0] cnt_q;
    reg [`CNT_W-1:0] cnt_d;
    reg [`CNT_W-1:0] held_q;
    reg [7:0] hi_cap_q;
    reg [`CNT_W-1:0] base;
    wire inc;

    assign inc = i_evt & ~i_freeze;

    always @*
    begin
        base = cnt_q;
        if (i_latch_en && i_tick)
        begin
            base = `CNT_ZERO;
        end
        else if (!i_latch_en && i_rd_lo)
        begin
            base = {cnt_q[15:8], `BYTE_ZERO};
        end
        else if (!i_latch_en && i_rd_hi)
        begin
            base = {`BYTE_ZERO, cnt_q[7:0]};
        end
        // an event in the clearing cycle is kept: it counts into the cleared value
        cnt_d = base;
        if (inc && base != `CNT_MAX)
        begin
            cnt_d = base + {{(`CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            cnt_q <= `CNT_ZERO;
            held_q <= `CNT_ZERO;
            hi_cap_q <= `BYTE_ZERO;
        end
        else
        begin
            cnt_q <= cnt_d;
            if (i_latch_en && i_tick)
            begin
                held_q <= cnt_q;
            end
            if (!i_latch_en && i_rd_lo)
            begin
                hi_cap_q <= cnt_q[15:8];
            end
        end
    end

    // latched mode shows the value frozen at the last tick for a whole second
    assign o_lo = i_latch_en ? held_q[7:0] : cnt_q[7:0];
    assign o_hi = i_latch_en ? held_q[15:8] : hi_cap_q;
endmodule // count_channel

`default_nettype wire

/* File: bench/host_port_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
    // answer from the device
    input wire logic i_clk_sys,
    input wire logic i_rvalid,
    input wire logic [7:0] i_rdata,
    // processor strobes
    output logic o_cs,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    initial
    begin
        {o_cs, o_wr, o_rd, o_addr, o_wdata} = 19'h00000;
    end
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys) #1;
        {o_cs, o_wr, o_addr, o_wdata} = {2'h3, a, d & 8'h0F};
        @(posedge i_clk_sys) #1;
        {o_cs, o_wr, o_addr, o_wdata} = {2'h0, ~a, ~d};
    endtask
    // the strobe stays one cycle, since each pulse on a counter address clears in unlatched mode;
    // the answer is taken at the following edge, where o_rvalid stands high
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk_sys) #1;
        {o_cs, o_rd, o_addr} = {2'h3, a};
        @(posedge i_clk_sys) #1;
        {o_cs, o_rd, o_addr} = {2'h0, ~a};
        @(posedge i_clk_sys);
        d = i_rvalid ? i_rdata : 8'hXX;
        #1;
    endtask
endmodule // host_port_model
`default_nettype wire

/* File: bench/rx_counter_latch_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_counter_latch_chk #(parameter [27:0] ONE_SEC_CYCLES = 28'h0000032) (
    // watched ports
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_cs,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic i_carrier_group_alarm,
    input wire logic i_cga_from_yellow,
    input wire logic i_e1_mode,
    input wire logic o_one_second_tick,
    input wire logic o_perf_inhibit,
    input wire logic o_lof_timeout_valid,
    input wire logic o_alarm_status_hold_en,
    input wire logic o_error_status_latch_en,
    input wire logic i_rx_frame_loss,
    input wire logic i_rx_signal_loss,
    input wire logic i_rx_all_ones_alarm,
    input wire logic o_counts_frozen
);
    logic [27:0] gap_q;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    // cycles since the last tick pulse, to bound how rare the tick may get
    always @(posedge i_clk_sys)
    begin
        if (i_srst || o_one_second_tick)
            gap_q <= 28'h0000000;
        else
            gap_q <= gap_q + 28'h0000001;
    end
    property p_rv; i_cs && i_rd |=> o_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_rq; !(i_cs && i_rd) |=> !o_rvalid; endproperty
    a_rq: assert property (p_rq) else $error("spurious answer");
    property p_hold; !(i_cs && i_rd) |=> $stable(o_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_res; i_cs && i_rd && i_addr == 8'h46 |=> o_rdata[7:4] == 4'h0; endproperty
    a_res: assert property (p_res) else $error("reserved bits set");
    property p_cfg; i_cs && i_wr && i_addr == 8'h46 ##1 !(i_cs && i_wr) |=>
        {o_error_status_latch_en, o_alarm_status_hold_en} == $past(i_wdata[1:0], 2); endproperty
    a_cfg: assert property (p_cfg) else $error("config bits wrong");
    property p_lof; i_cs && i_wr && i_addr == 8'h46 && i_wdata[2] && i_e1_mode ##1
        i_e1_mode && !(i_cs && i_wr) |=> !o_lof_timeout_valid; endproperty
    a_lof: assert property (p_lof) else $error("timeout still valid");
    property p_inh; 1 |=> o_perf_inhibit == ($past(i_carrier_group_alarm) && !$past(i_cga_from_yellow));
    endproperty
    a_inh: assert property (p_inh) else $error("inhibit wrong");
    property p_tick; o_one_second_tick |=> !o_one_second_tick [*8]; endproperty
    a_tick: assert property (p_tick) else $error("tick too close");
    property p_gap; !(gap_q > ONE_SEC_CYCLES + 28'h0000001); endproperty
    a_gap: assert property (p_gap) else $error("tick missing");
    property p_frz; o_counts_frozen |-> $past(i_rx_frame_loss || i_rx_signal_loss || i_rx_all_ones_alarm);
    endproperty
    a_frz: assert property (p_frz) else $error("frozen without alarm");
endmodule // rx_counter_latch_chk
bind rx_counter_latch_config rx_counter_latch_chk #(.ONE_SEC_CYCLES(ONE_SEC_CYCLES)) chk_i (.i_clk_sys, .i_srst,
    .i_cs, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .o_rvalid, .i_carrier_group_alarm, .i_cga_from_yellow,
    .i_e1_mode, .o_one_second_tick, .o_perf_inhibit, .o_lof_timeout_valid, .o_alarm_status_hold_en,
    .o_error_status_latch_en, .i_rx_frame_loss, .i_rx_signal_loss, .i_rx_all_ones_alarm, .o_counts_frozen);
`default_nettype wire

/* File: bench/rx_counter_latch_config_test.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_counter_latch_config_test;
    logic i_clk_sys, i_srst, i_cs, i_wr, i_rd, i_rx_frame_loss, i_rx_signal_loss, i_rx_all_ones_alarm;
    logic i_carrier_group_alarm, i_cga_from_yellow, i_e1_mode, i_test_pattern_err, o_rvalid, o_one_second_tick;
    logic o_perf_inhibit, o_lof_timeout_valid, o_alarm_status_hold_en, o_error_status_latch_en, o_counts_frozen;
    logic [7:0] i_addr, i_wdata, o_rdata, d;
    logic [3:0] i_err_evt;
    integer err_count = 0, n_tests = 0, cyc = 0, k;
    rx_counter_latch_config #(.ONE_SEC_CYCLES(28'h0000032)) rx_counter_latch_config_i (.i_clk_sys, .i_srst,
        .i_cs, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .o_rvalid, .i_rx_frame_loss, .i_rx_signal_loss,
        .i_rx_all_ones_alarm, .i_carrier_group_alarm, .i_cga_from_yellow, .i_e1_mode, .i_err_evt,
        .i_test_pattern_err, .o_one_second_tick, .o_perf_inhibit, .o_lof_timeout_valid, .o_alarm_status_hold_en,
        .o_error_status_latch_en, .o_counts_frozen);
    host_port_model host_port_model_i (.i_clk_sys, .i_rvalid(o_rvalid), .i_rdata(o_rdata), .o_cs(i_cs),
        .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
    initial
    begin
        i_clk_sys = 0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end
    task summarize;
        $display("errors %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            summarize;
        end
    end
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task rc(input logic [7:0] a, input logic [7:0] e);
        host_port_model_i.rd(a, d);
        chk(d, e);
    endtask
    task ev(input logic [3:0] e, input logic t, input integer n);
        repeat (n)
        begin
            @(posedge i_clk_sys) #1;
            {i_err_evt, i_test_pattern_err} = {e, t};
        end
        @(posedge i_clk_sys) #1;
        {i_err_evt, i_test_pattern_err} = 5'h00;
    endtask
    // bounded wait for the per-second pulse
    task wt;
        for (k = 0; k < 200 && o_one_second_tick !== 1'b1; k++)
            @(posedge i_clk_sys) #1;
        chk({7'h00, o_one_second_tick}, 8'h01);
    endtask
    initial
    begin
        {i_srst, i_rx_frame_loss, i_rx_signal_loss, i_rx_all_ones_alarm} = 4'h8;
        {i_carrier_group_alarm, i_cga_from_yellow, i_e1_mode, i_err_evt, i_test_pattern_err} = 8'h00;
        repeat (4) @(posedge i_clk_sys);
        #1 i_srst = 0;
        rc(8'h46, 8'h00);
        host_port_model_i.wr(8'h46, 8'h0B);
        rc(8'h46, 8'h0B);
        chk({6'h00, o_error_status_latch_en, o_alarm_status_hold_en}, 8'h03);
        i_rx_frame_loss = 1;
        ev(4'h1, 1, 3);
        chk({7'h00, o_counts_frozen}, 8'h01);
        i_rx_frame_loss = 0;
        ev(4'h1, 0, 2);
        rc(8'h50, 8'h02);
        rc(8'h58, 8'h03);
        ev(4'h2, 0, 261);
        rc(8'h52, 8'h05);
        ev(4'h2, 0, 4);
        rc(8'h53, 8'h01);
        rc(8'h52, 8'h04);
        rc(8'h53, 8'h00);
        rc(8'h00, 8'h00);
        i_e1_mode = 1;
        host_port_model_i.wr(8'h46, 8'h04);
        wt;
        ev(4'h4, 1, 7);
        wt;
        rc(8'h54, 8'h07);
        rc(8'h54, 8'h07);
        rc(8'h58, 8'h07);
        chk({7'h00, o_lof_timeout_valid}, 8'h00);
        i_carrier_group_alarm = 1;
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk({7'h00, o_perf_inhibit}, 8'h01);
        i_cga_from_yellow = 1;
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk({7'h00, o_perf_inhibit}, 8'h00);
        host_port_model_i.wr(8'h46, 8'h08);
        i_rx_signal_loss = 1;
        ev(4'h8, 0, 2);
        chk({7'h00, o_counts_frozen}, 8'h01);
        {i_rx_signal_loss, i_rx_all_ones_alarm} = 2'h1;
        ev(4'h8, 0, 2);
        chk({7'h00, o_counts_frozen}, 8'h01);
        rc(8'h56, 8'h00);
        i_rx_all_ones_alarm = 0;
        ev(4'h8, 0, 1);
        chk({7'h00, o_counts_frozen}, 8'h00);
        rc(8'h56, 8'h01);
        chk({7'h00, o_lof_timeout_valid}, 8'h01);
        summarize;
    end
endmodule // rx_counter_latch_config_test
`default_nettype wire
